// ### led_seq_pkg.sv
package led_seq_pkg;

   // system clock and timed delays
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int unsigned OSC_SETTLE_MS = 10;
   localparam int unsigned SOFT_START_MS = 20;
   localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_MS * (CLK_HZ / 1000);
   localparam int unsigned SOFT_START_CYC = SOFT_START_MS * (CLK_HZ / 1000);

   // boost switching clock and pulse widths
   localparam int unsigned BOOST_HZ = 1_000_000;
   localparam int unsigned BOOST_DIV = CLK_HZ / BOOST_HZ;
   localparam int unsigned MIN_PULSE_NS = 45;
   localparam int unsigned MIN_PULSE_RAW = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_RAW < 1) ? 1 : MIN_PULSE_RAW;
   localparam int unsigned MAX_DUTY_PCT = 80;
   localparam int unsigned MAX_ON_CYC = BOOST_DIV * MAX_DUTY_PCT / 100;

   // register map
   localparam logic [7:0] BOOST_VOUT_ADDR = 8'h0d;
   localparam logic [7:0] CTRL_ADDR = 8'h0e;
   localparam logic [7:0] STATUS_ADDR = 8'h0f;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_BOOST_BIT = 1;
   localparam int unsigned CTRL_LOAD_BIT = 2;
   localparam logic [7:0] CTRL_RESET = 8'h04;
   localparam logic [7:0] BOOST_VOUT_RESET = 8'h08;
   localparam logic [7:0] VOUT_MIN = 8'h08;
   localparam logic [7:0] VOUT_MAX = 8'h12;

   // serial link address, arbitrary value
   localparam logic [6:0] LINK_ADDR = 7'h2c;

   typedef enum logic [2:0] {
      MODE_RESET,
      MODE_STANDBY,
      MODE_STARTUP,
      MODE_BOOST_START,
      MODE_NORMAL
   } mode_e;

endpackage

// ### reg_bus_if.sv
interface reg_bus_if;
   logic wr_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport link (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ### serial_reg_link.sv
module serial_reg_link (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_b_o,
   reg_bus_if.link bus
);

   typedef enum logic [2:0] {
      L_IDLE,
      L_DEV,
      L_ACK,
      L_WR,
      L_RD,
      L_RD_ACK
   } link_e;

   link_e st_ff;
   logic scl_q_ff;
   logic sda_q_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic [7:0] ptr_ff;
   logic [7:0] wdata_ff;
   logic rw_ff;
   logic first_ff;
   logic nack_ff;
   logic drive_ff;
   logic wr_ff;

   // bus condition decode
   wire start_det = scl_i && scl_q_ff && sda_q_ff && !sda_i;
   wire stop_det = scl_i && scl_q_ff && !sda_q_ff && sda_i;
   wire scl_rise = scl_i && !scl_q_ff;
   wire scl_fall = !scl_i && scl_q_ff;
   wire [7:0] sh_in = {sh_ff[6:0], sda_i};

   assign sda_oe_b_o = !drive_ff; // open drain: only ever pulls low
   assign bus.wr_stb = wr_ff;
   assign bus.addr = ptr_ff;
   assign bus.wdata = wdata_ff;

   // pin sampling for edge detection
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl_i;
         sda_q_ff <= sda_i;
      end
   end

   // byte engine: address, pointer, write data, read data
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff <= L_IDLE;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         ptr_ff <= 8'h00;
         wdata_ff <= 8'h00;
         rw_ff <= 1'b0;
         first_ff <= 1'b0;
         nack_ff <= 1'b0;
         drive_ff <= 1'b0;
         wr_ff <= 1'b0;
      end else if (clear_i) begin
         st_ff <= L_IDLE;
         drive_ff <= 1'b0;
         wr_ff <= 1'b0;
         ptr_ff <= 8'h00;
      end else begin
         wr_ff <= 1'b0;
         if (start_det) begin
            st_ff <= L_DEV;
            cnt_ff <= 4'h0;
            drive_ff <= 1'b0;
         end else if (stop_det) begin
            st_ff <= L_IDLE;
            drive_ff <= 1'b0;
         end else if (scl_rise) begin
            if (st_ff == L_DEV || st_ff == L_WR) begin
               sh_ff <= sh_in;
               cnt_ff <= cnt_ff + 4'h1;
            end else if (st_ff == L_RD_ACK) begin
               nack_ff <= sda_i;
            end
         end else if (scl_fall) begin
            unique case (st_ff)
               L_IDLE: ;
               L_DEV: begin
                  if (cnt_ff == 4'h8) begin
                     if (sh_ff[7:1] == led_seq_pkg::LINK_ADDR) begin
                        st_ff <= L_ACK;
                        drive_ff <= 1'b1;
                        rw_ff <= sh_ff[0];
                        first_ff <= !sh_ff[0];
                     end else begin
                        st_ff <= L_IDLE;
                     end
                  end
               end
               L_WR: begin
                  if (cnt_ff == 4'h8) begin
                     st_ff <= L_ACK;
                     drive_ff <= 1'b1;
                     if (first_ff) begin
                        ptr_ff <= sh_ff;
                        first_ff <= 1'b0;
                     end else begin
                        wdata_ff <= sh_ff;
                        wr_ff <= 1'b1;
                     end
                  end
               end
               L_ACK, L_RD_ACK: begin
                  cnt_ff <= 4'h0;
                  if (rw_ff && !(st_ff == L_RD_ACK && nack_ff)) begin
                     st_ff <= L_RD;
                     sh_ff <= bus.rdata;
                     drive_ff <= !bus.rdata[7];
                     cnt_ff <= 4'h1;
                  end else if (rw_ff) begin
                     st_ff <= L_IDLE;
                     drive_ff <= 1'b0;
                  end else begin
                     st_ff <= L_WR;
                     drive_ff <= 1'b0;
                  end
               end
               L_RD: begin
                  if (cnt_ff == 4'h8) begin
                     st_ff <= L_RD_ACK;
                     drive_ff <= 1'b0;
                  end else begin
                     drive_ff <= !sh_ff[3'(4'h7 - cnt_ff)];
                     cnt_ff <= cnt_ff + 4'h1;
                  end
               end
            endcase
         end
      end
   end

endmodule

// ### led_unit_mode_sequencer_boost_ctrl.sv
// How it works
// - in reset mode every register is forced back to its default value
// - external low reset or power-on reset forces reset mode from any mode
// - power-on reset holds reset mode; its release moves on to standby
// - run-request bit defaults to zero, so the unit rests in standby
// - run-request zero and no reset means standby with everything disabled
// - writes land in standby and take effect at once; boost enable acts only after startup
// - run request starts core power and holds a 10 ms oscillator settle delay
// - thermal shutdown stops operation and holds startup until it clears
// - boost soft-start runs low-current switching for 20 ms, then normal switching
// - all LED outputs stay off during the boost soft-start delay
// - soft-start follows startup with boost enabled, or boost enable written in normal
// - normal mode takes writes in any order, many bits at once
// - boost enable written zero puts the converter in its standby state
// - the 8-bit output code 8..18 selects 8 V to 18 V in 1 V steps
// - stored codes below 8 are used as 8
// - stored codes above 18 are used as 18
// - active load is on while the converter runs, unless software clears its enable bit
// - switch on-time is capped by a digital duty limit
// - switching clock is a divided down copy of the oscillator, 1 MHz nominal
// - every switching cycle gives at least a minimum-length pulse
// - the output voltage register lives at address 0x0d
module led_unit_mode_sequencer_boost_ctrl #(
   parameter int unsigned OSC_SETTLE_CYC = led_seq_pkg::OSC_SETTLE_CYC,
   parameter int unsigned SOFT_START_CYC = led_seq_pkg::SOFT_START_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic external_reset_low_i,
   input wire logic por_active_i,
   input wire logic thermal_shutdown_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_b_o,
   input wire logic peak_current_i,
   output logic core_power_o,
   output logic led_enable_o,
   output logic boost_active_o,
   output logic boost_low_current_o,
   output logic boost_switch_o,
   output logic active_load_o,
   output logic [7:0] vout_code_o,
   output logic [2:0] mode_o
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   localparam int TMR_W = 24;

   reg_bus_if bus ();

   led_seq_pkg::mode_e mode_ff;
   led_seq_pkg::mode_e nxt_mode;
   logic [TMR_W-1:0] tmr_ff;
   logic [TMR_W-1:0] nxt_tmr;
   logic [7:0] ctrl_ff;
   logic [7:0] vout_ff;
   logic [7:0] vout_code_ff;
   logic boost_up_ff;
   logic boost_en_q_ff;
   logic [3:0] div_ff;
   logic [3:0] on_cnt_ff;
   logic sw_ff;

   // clamp a stored voltage code into the usable 8..18 range
   function automatic logic [7:0] clamp_vout(input logic [7:0] code);
      if (code < led_seq_pkg::VOUT_MIN) begin
         return led_seq_pkg::VOUT_MIN;
      end else if (code > led_seq_pkg::VOUT_MAX) begin
         return led_seq_pkg::VOUT_MAX;
      end
      return code;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset request and control bit decode

   wire reset_req = !external_reset_low_i || por_active_i;
   wire run_req = ctrl_ff[led_seq_pkg::CTRL_RUN_BIT];
   wire boost_en = ctrl_ff[led_seq_pkg::CTRL_BOOST_BIT];
   wire load_en = ctrl_ff[led_seq_pkg::CTRL_LOAD_BIT];
   wire tmr_done = (tmr_ff == '0);
   wire in_run = (mode_ff == led_seq_pkg::MODE_BOOST_START) ||
                 (mode_ff == led_seq_pkg::MODE_NORMAL);
   wire boost_rise = boost_en && !boost_en_q_ff;

   ////////////////////////////////////////////////////////////////////////
   // serial register link

   serial_reg_link u_link (
      .clk_sys_i (clk_sys_i),
      .rst_b_i (rst_b_i),
      .clear_i (reset_req),
      .scl_i (scl_i),
      .sda_i (sda_i),
      .sda_oe_b_o (sda_oe_b_o),
      .bus (bus.link)
   );

   // register write decode, accepted in every mode except reset
   wire wr_ctrl = bus.wr_stb && (bus.addr == led_seq_pkg::CTRL_ADDR);
   wire wr_vout = bus.wr_stb && (bus.addr == led_seq_pkg::BOOST_VOUT_ADDR);

   // read back selection; status shows the live mode
   assign bus.rdata = (bus.addr == led_seq_pkg::CTRL_ADDR) ? ctrl_ff :
                      (bus.addr == led_seq_pkg::BOOST_VOUT_ADDR) ? vout_ff :
                      (bus.addr == led_seq_pkg::STATUS_ADDR) ?
                      {3'h0, boost_up_ff, thermal_shutdown_i, 3'(mode_ff)} :
                      8'h00;

   ////////////////////////////////////////////////////////////////////////
   // control registers

   // whole writes replace every bit at once; reset mode restores defaults
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_ff <= led_seq_pkg::CTRL_RESET;
         vout_ff <= led_seq_pkg::BOOST_VOUT_RESET;
      end else if (reset_req) begin
         ctrl_ff <= led_seq_pkg::CTRL_RESET;
         vout_ff <= led_seq_pkg::BOOST_VOUT_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= bus.wdata;
         end
         if (wr_vout) begin
            vout_ff <= bus.wdata;
         end
      end
   end

   // clamped voltage code held in a register for the analog divider
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vout_code_ff <= led_seq_pkg::VOUT_MIN;
      end else begin
         vout_code_ff <= clamp_vout(vout_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operating mode sequencer

   // next mode and delay timer load
   always_comb begin
      nxt_mode = mode_ff;
      nxt_tmr = (tmr_ff == '0) ? tmr_ff : tmr_ff - TMR_W'(1);
      if (reset_req) begin
         nxt_mode = led_seq_pkg::MODE_RESET;
         nxt_tmr = '0;
      end else begin
         unique case (mode_ff)
            led_seq_pkg::MODE_RESET: begin
               nxt_mode = led_seq_pkg::MODE_STANDBY;
            end
            led_seq_pkg::MODE_STANDBY: begin
               if (run_req) begin
                  nxt_mode = led_seq_pkg::MODE_STARTUP;
                  nxt_tmr = TMR_W'(OSC_SETTLE_CYC);
               end
            end
            led_seq_pkg::MODE_STARTUP: begin
               if (!run_req) begin
                  nxt_mode = led_seq_pkg::MODE_STANDBY;
               end else if (thermal_shutdown_i) begin
                  nxt_tmr = TMR_W'(OSC_SETTLE_CYC);
               end else if (tmr_done && boost_en) begin
                  nxt_mode = led_seq_pkg::MODE_BOOST_START;
                  nxt_tmr = TMR_W'(SOFT_START_CYC);
               end else if (tmr_done) begin
                  nxt_mode = led_seq_pkg::MODE_NORMAL;
               end
            end
            led_seq_pkg::MODE_BOOST_START: begin
               if (!run_req) begin
                  nxt_mode = led_seq_pkg::MODE_STANDBY;
               end else if (thermal_shutdown_i) begin
                  nxt_mode = led_seq_pkg::MODE_STARTUP;
                  nxt_tmr = TMR_W'(OSC_SETTLE_CYC);
               end else if (!boost_en || tmr_done) begin
                  nxt_mode = led_seq_pkg::MODE_NORMAL;
               end
            end
            led_seq_pkg::MODE_NORMAL: begin
               if (!run_req) begin
                  nxt_mode = led_seq_pkg::MODE_STANDBY;
               end else if (thermal_shutdown_i) begin
                  nxt_mode = led_seq_pkg::MODE_STARTUP;
                  nxt_tmr = TMR_W'(OSC_SETTLE_CYC);
               end else if (boost_en && !boost_up_ff) begin
                  nxt_mode = led_seq_pkg::MODE_BOOST_START;
                  nxt_tmr = TMR_W'(SOFT_START_CYC);
               end
            end
         endcase
      end
   end

   // mode and timer registers
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_ff <= led_seq_pkg::MODE_RESET;
         tmr_ff <= '0;
      end else begin
         mode_ff <= nxt_mode;
         tmr_ff <= nxt_tmr;
      end
   end

   // converter running flag: set at soft-start end, dropped on disable
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         boost_up_ff <= 1'b0;
         boost_en_q_ff <= 1'b0;
      end else begin
         boost_en_q_ff <= boost_en;
         if (!boost_en || reset_req || !in_run) begin
            boost_up_ff <= 1'b0;
         end else if (mode_ff == led_seq_pkg::MODE_BOOST_START && tmr_done) begin
            boost_up_ff <= 1'b1;
         end else if (boost_rise) begin
            boost_up_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // boost switching control

   // switching clock enable divided from the system clock
   wire sw_tick = (div_ff == 4'(led_seq_pkg::BOOST_DIV - 1));
   wire converter_on = in_run && boost_en && !thermal_shutdown_i;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_ff <= 4'h0;
      end else if (sw_tick || !converter_on) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end

   // switch pulse: at least the minimum width, ended by peak current, capped
   wire min_met = (on_cnt_ff >= 4'(led_seq_pkg::MIN_PULSE_CYC));
   wire max_hit = (on_cnt_ff >= 4'(led_seq_pkg::MAX_ON_CYC));

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sw_ff <= 1'b0;
         on_cnt_ff <= 4'h0;
      end else if (!converter_on) begin
         sw_ff <= 1'b0;
         on_cnt_ff <= 4'h0;
      end else if (sw_tick) begin
         sw_ff <= 1'b1;
         on_cnt_ff <= 4'h1;
      end else if (sw_ff) begin
         if (max_hit || (min_met && peak_current_i)) begin
            sw_ff <= 1'b0;
         end else begin
            on_cnt_ff <= on_cnt_ff + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign core_power_o = (mode_ff == led_seq_pkg::MODE_STARTUP) || in_run;
   assign led_enable_o = (mode_ff == led_seq_pkg::MODE_NORMAL) && !thermal_shutdown_i;
   assign boost_active_o = converter_on;
   assign boost_low_current_o = (mode_ff == led_seq_pkg::MODE_BOOST_START);
   assign boost_switch_o = sw_ff;
   assign active_load_o = converter_on && load_en;
   assign vout_code_o = vout_code_ff;
   assign mode_o = 3'(mode_ff);

endmodule

// ### mode_seq_checker.sv
module mode_seq_checker #(
   parameter int unsigned OSC_SETTLE_CYC = led_seq_pkg::OSC_SETTLE_CYC,
   parameter int unsigned SOFT_START_CYC = led_seq_pkg::SOFT_START_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic external_reset_low_i,
   input wire logic por_active_i,
   input wire logic thermal_shutdown_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_oe_b_o,
   input wire logic peak_current_i,
   input wire logic core_power_o,
   input wire logic led_enable_o,
   input wire logic boost_active_o,
   input wire logic boost_low_current_o,
   input wire logic boost_switch_o,
   input wire logic active_load_o,
   input wire logic [7:0] vout_code_o,
   input wire logic [2:0] mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned soft_cnt_ff;
   int unsigned nxt_soft_cnt;

   // cycles spent in soft-start, so an overlong soft-start shows
   assign nxt_soft_cnt = (mode_o == 3'h3) ? soft_cnt_ff + 1 : 0;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i)
         soft_cnt_ff <= 0;
      else
         soft_cnt_ff <= nxt_soft_cnt;
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // mode and output relations
   ext_reset_a: assert property (!external_reset_low_i |=> mode_o == 3'h0)
      else $error("external reset did not force reset mode");
   por_reset_a: assert property (por_active_i |=> mode_o == 3'h0)
      else $error("power-on reset did not force reset mode");
   reset_exit_a: assert property (mode_o == 3'h0 && external_reset_low_i && !por_active_i |=> mode_o == 3'h1)
      else $error("reset release did not lead to standby");
   soft_led_off_a: assert property (mode_o == 3'h3 |-> !led_enable_o && boost_low_current_o)
      else $error("leds on or full current during soft-start");
   soft_length_a: assert property (soft_cnt_ff <= SOFT_START_CYC + 1)
      else $error("soft-start lasted too long");
   core_power_a: assert property (core_power_o == (mode_o >= 3'h2))
      else $error("core power does not follow mode");
   load_gate_a: assert property (active_load_o |-> boost_active_o)
      else $error("active load on with converter stopped");
   duty_cap_a: assert property (boost_switch_o [*8] |=> !boost_switch_o)
      else $error("switch on-time beyond duty limit");
   thermal_stop_a: assert property (thermal_shutdown_i && mode_o == 3'h4 && external_reset_low_i && !por_active_i
      |=> mode_o == 3'h2)
      else $error("thermal event did not return to startup");
   led_mode_a: assert property (led_enable_o |-> mode_o == 3'h4)
      else $error("leds enabled outside normal mode");
   vout_clamp_a: assert property (vout_code_o >= 8'h08 && vout_code_o <= 8'h12)
      else $error("voltage code outside clamp range");
   boost_idle_a: assert property (!boost_active_o [*8] |-> !boost_switch_o)
      else $error("switching with converter in standby");
endmodule

bind led_unit_mode_sequencer_boost_ctrl mode_seq_checker #(.OSC_SETTLE_CYC(OSC_SETTLE_CYC),
   .SOFT_START_CYC(SOFT_START_CYC)) u_chk (.clk_sys_i, .rst_b_i, .external_reset_low_i, .por_active_i,
   .thermal_shutdown_i, .scl_i, .sda_i, .sda_oe_b_o, .peak_current_i, .core_power_o, .led_enable_o,
   .boost_active_o, .boost_low_current_o, .boost_switch_o, .active_load_o, .vout_code_o, .mode_o);

// ### host_link_model.sv
module host_link_model (
   input wire logic clk_i,
   input wire logic sda_w_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus: both lines released high
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // wait n clocks, then move just after the edge
   task automatic hc(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask

   // one bit; data moves only while scl is low, phases of several clocks
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      hc(3);
      scl_o = 1'b1;
      hc(2);
      r = sda_w_i;
      hc(1);
      scl_o = 1'b0;
      hc(1);
   endtask

   // a byte msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] b, input logic ack_in, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(ack_in, ack);
      ack = !ack;
   endtask

   task automatic start_c();
      sda_o = 1'b1;
      hc(3);
      scl_o = 1'b1;
      hc(3);
      sda_o = 1'b0;
      hc(3);
      scl_o = 1'b0;
      hc(3);
   endtask

   task automatic stop_c();
      sda_o = 1'b0;
      hc(3);
      scl_o = 1'b1;
      hc(3);
      sda_o = 1'b1;
      hc(3);
   endtask

   // register write; ok only if all three bytes were acknowledged
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic k0, k1, k2;
      start_c();
      xfer({dev, 1'b0}, 1'b1, r, k0);
      xfer(a, 1'b1, r, k1);
      xfer(d, 1'b1, r, k2);
      stop_c();
      ok = k0 & k1 & k2;
   endtask

   // pointer write, repeated start, one byte read ended by a nack
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic k;
      start_c();
      xfer({led_seq_pkg::LINK_ADDR, 1'b0}, 1'b1, r, k);
      xfer(a, 1'b1, r, k);
      start_c();
      xfer({led_seq_pkg::LINK_ADDR, 1'b1}, 1'b1, r, k);
      xfer(8'hff, 1'b1, d, k);
      stop_c();
   endtask
endmodule

// ### led_unit_mode_sequencer_boost_ctrl_bench.sv
module led_unit_mode_sequencer_boost_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned OSC = 20;
   localparam int unsigned SOFT = 30;
   logic clk_sys_i = 1'b0, rst_b_i = 1'b0, external_reset_low_i = 1'b1, por_active_i = 1'b0;
   logic thermal_shutdown_i = 1'b0, peak_current_i = 1'b0, scl_i, sda_i, host_sda, sda_oe_b_o;
   logic core_power_o, led_enable_o, boost_active_o, boost_low_current_o, boost_switch_o, active_load_o;
   logic [7:0] vout_code_o;
   logic [2:0] mode_o, last_mode;
   int unsigned run_len, fail_count, check_count;
   logic saw_soft;

   always #50 clk_sys_i = ~clk_sys_i;
   // open-drain data wire with pull-up
   assign sda_i = host_sda & sda_oe_b_o;

   led_unit_mode_sequencer_boost_ctrl #(.OSC_SETTLE_CYC(OSC), .SOFT_START_CYC(SOFT)) dut (.clk_sys_i, .rst_b_i,
      .external_reset_low_i, .por_active_i, .thermal_shutdown_i, .scl_i, .sda_i, .sda_oe_b_o, .peak_current_i,
      .core_power_o, .led_enable_o, .boost_active_o, .boost_low_current_o, .boost_switch_o, .active_load_o,
      .vout_code_o, .mode_o);
   host_link_model host (.clk_i(clk_sys_i), .sda_w_i(sda_i), .scl_o(scl_i), .sda_o(host_sda));

   // cycles spent so far in the mode seen before each edge
   always @(posedge clk_sys_i) begin
      if (mode_o !== last_mode) run_len = 0;
      run_len++;
      last_mode = mode_o;
      if (mode_o === 3'h3) saw_soft = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #5;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      host.write_reg(led_seq_pkg::LINK_ADDR, a, d, ok);
      chk("write ack", 8'h01, 8'(ok));
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.read_reg(a, d);
      chk("read data", exp, d);
   endtask

   task automatic to_mode(input logic [2:0] m);
      for (int i = 0; i < 1000 && mode_o !== m; i++) cyc(1);
      chk("mode", 8'(m), 8'(mode_o));
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      logic ok;
      chk("mode", 8'h01, 8'(mode_o));
      chk("core power", 8'h00, 8'(core_power_o));
      chk("vout code", 8'h08, vout_code_o);
      rd(8'h0d, led_seq_pkg::BOOST_VOUT_RESET);
      rd(8'h0e, led_seq_pkg::CTRL_RESET);
      rd(8'h30, 8'h00);
      rd(8'h0f, 8'h01);
      host.write_reg(led_seq_pkg::LINK_ADDR ^ 7'h01, 8'h0d, 8'h10, ok);
      chk("foreign address ack", 8'h00, 8'(ok));
      $display("defaults done");
   endtask

   task automatic t_vout();
      logic [7:0] raw[7] = '{8'h00, 8'h07, 8'h08, 8'h0d, 8'h12, 8'h13, 8'hff};
      logic [7:0] use_v[7] = '{8'h08, 8'h08, 8'h08, 8'h0d, 8'h12, 8'h12, 8'h12};
      for (int i = 0; i < 7; i++) begin
         wr(8'h0d, raw[i]);
         cyc(2);
         chk("vout code", use_v[i], vout_code_o);
         rd(8'h0d, raw[i]);
      end
      $display("voltage clamp done");
   endtask

   task automatic t_switch(input logic pk, input int unsigned on_exp);
      int unsigned run = 0, mx = 0, edges = 0;
      logic prev;
      peak_current_i = pk;
      cyc(10);
      prev = boost_switch_o;
      repeat (100) begin
         cyc(1);
         if (boost_switch_o && !prev) edges++;
         run = boost_switch_o ? run + 1 : 0;
         if (run > mx) mx = run;
         prev = boost_switch_o;
      end
      chk("on time", 8'(on_exp), 8'(mx));
      chk("pulses", 8'(100 / led_seq_pkg::BOOST_DIV), 8'(edges));
      peak_current_i = 1'b0;
   endtask

   task automatic t_startup();
      wr(8'h0e, 8'h06);
      cyc(30);
      chk("mode", 8'h01, 8'(mode_o));
      wr(8'h0e, 8'h07);
      to_mode(3'h3);
      chk("settle ok", 8'h01, 8'(run_len >= OSC && run_len <= OSC + 2));
      chk("led enable", 8'h00, 8'(led_enable_o));
      chk("low current", 8'h01, 8'(boost_low_current_o));
      to_mode(3'h4);
      chk("soft ok", 8'h01, 8'(run_len >= SOFT && run_len <= SOFT + 2));
      chk("led enable", 8'h01, 8'(led_enable_o));
      chk("active load", 8'h01, 8'(active_load_o));
      t_switch(1'b0, led_seq_pkg::MAX_ON_CYC);
      t_switch(1'b1, led_seq_pkg::MIN_PULSE_CYC);
      $display("startup done");
   endtask

   task automatic t_runtime();
      wr(8'h0e, 8'h03);
      cyc(2);
      chk("active load", 8'h00, 8'(active_load_o));
      wr(8'h0e, 8'h01);
      cyc(2);
      chk("boost active", 8'h00, 8'(boost_active_o));
      wr(8'h0e, 8'h03);
      to_mode(3'h3);
      to_mode(3'h4);
      thermal_shutdown_i = 1'b1;
      cyc(2);
      chk("mode", 8'h02, 8'(mode_o));
      cyc(40);
      chk("mode", 8'h02, 8'(mode_o));
      chk("led enable", 8'h00, 8'(led_enable_o));
      rd(8'h0f, 8'h0a);
      thermal_shutdown_i = 1'b0;
      to_mode(3'h3);
      to_mode(3'h4);
      wr(8'h0e, 8'h00);
      to_mode(3'h1);
      saw_soft = 1'b0;
      wr(8'h0e, 8'h05);
      to_mode(3'h4);
      chk("soft seen", 8'h00, 8'(saw_soft));
      chk("boost active", 8'h00, 8'(boost_active_o));
      $display("runtime done");
   endtask

   task automatic t_resets();
      wr(8'h0d, 8'h10);
      external_reset_low_i = 1'b0;
      cyc(2);
      chk("mode", 8'h00, 8'(mode_o));
      external_reset_low_i = 1'b1;
      cyc(2);
      chk("mode", 8'h01, 8'(mode_o));
      rd(8'h0e, led_seq_pkg::CTRL_RESET);
      rd(8'h0d, led_seq_pkg::BOOST_VOUT_RESET);
      wr(8'h0e, 8'h05);
      to_mode(3'h4);
      por_active_i = 1'b1;
      cyc(2);
      chk("mode", 8'h00, 8'(mode_o));
      por_active_i = 1'b0;
      cyc(2);
      chk("mode", 8'h01, 8'(mode_o));
      $display("resets done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(16);
      rst_b_i = 1'b1;
      cyc(2);
      t_defaults();
      t_vout();
      t_startup();
      t_runtime();
      t_resets();
      wrap_up();
   end

   // watchdog well beyond the expected run length
   initial begin
      repeat (80000) @(posedge clk_sys_i);
      fail_count++;
      wrap_up();
   end
endmodule
